/* rtl/pubu_core.sv */
// Command interpreter for pin unblock and binary update
`timescale 1ns/1ps
module pubu_core (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CMD_VALID,
  input wire pubu_pkg::pubu_hdr_t CMD_HDR,
  input wire logic [127:0] CMD_DATA,
  input wire logic [7:0] USB_P3,
  input wire logic USB_MODE,
  input wire logic USB_LEN_MISMATCH,
  input wire logic SECURE_MODE,
  input wire logic [7:0] DATA_COUNT,
  input wire pubu_pkg::pubu_file_t SEL_FILE,
  input wire logic [63:0] UNBLOCK_KEY_ONE,
  input wire logic [63:0] UNBLOCK_KEY_TWO,
  input wire logic PIN_FAIL,
  input wire logic PIN_FAIL_SEL,
  input wire logic [7:0] PIN_CFG_ONE,
  input wire logic [7:0] PIN_CFG_TWO,
  input wire logic APP_AUTH_KEY_WRITE,
  input wire logic APP_AUTH_KEY_SEL,
  input wire logic [7:0] APP_AUTH_KEY_VALUE,
  input wire logic NVM_FAULT,
  input wire logic TECH_FAULT,
  output logic BUSY,
  output logic RSP_VALID,
  output logic [15:0] RSP_SW,
  output logic NVM_WE,
  output logic [15:0] NVM_OFFSET,
  output logic [7:0] NVM_LEN,
  output logic [63:0] NEW_PIN,
  output logic [1:0] NEW_PIN_WE,
  output logic [1:0] PIN_BLOCKED,
  output logic [1:0] ACCESS_GRANT,
  output logic [7:0] UNB_LEFT_ONE,
  output logic [7:0] UNB_LEFT_TWO,
  output logic [7:0] UNB_MAX_ONE,
  output logic [7:0] UNB_MAX_TWO,
  output logic [7:0] MECH_ONE,
  output logic [7:0] MECH_TWO
);
  import pubu_pkg::*;

  pubu_state_t state;
  pubu_hdr_t hdr;
  logic [127:0] data;
  logic [7:0] dcount;
  logic sec;
  pubu_pin_t pin [2];
  logic [15:0] next_sw;
  logic next_commit;
  logic next_unb_ok;
  logic next_unb_bad;
  logic sel;
  logic [16:0] end_addr;
  logic unb_commit;

  assign sel = (hdr.p2 == P2_PIN_TWO); // RULE2
  assign end_addr = {1'b0, hdr.p1, hdr.p2} + {9'h000, hdr.lc}; // RULE20
  // Unblock outcome may touch counters only when memory reports no fault
  assign unb_commit = (state == ST_COMMIT) && !NVM_FAULT && (hdr.ins == INS_UNBLOCK); // RULE24

  // Decode of the captured command into a status word; first failing check wins
  always_comb begin
    next_sw = SW_OK;
    next_commit = 1'b0;
    next_unb_ok = 1'b0;
    next_unb_bad = 1'b0;
    if (TECH_FAULT) begin
      next_sw = SW_TECH; // RULE14
    end else if (USB_MODE && USB_LEN_MISMATCH) begin
      next_sw = {SW1_USB, USB_P3}; // RULE15
    end else if (hdr.ins == INS_UNBLOCK) begin
      if (hdr.cla != CLA_UNBLOCK) begin
        next_sw = SW_CLA; // RULE14
      end else if (hdr.p1 != P1_UNBLOCK ||
                   (hdr.p2 != P2_PIN_ONE && hdr.p2 != P2_PIN_TWO)) begin
        next_sw = SW_P1P2; // RULE13
      end else if (hdr.lc != LC_UNBLOCK || dcount != LC_UNBLOCK) begin
        next_sw = SW_LC; // RULE4
      end else if (pin[sel].unb_left == 8'h00) begin
        next_sw = SW_BLOCKED; // RULE9
      end else if (data[127:64] == (sel ? UNBLOCK_KEY_TWO : UNBLOCK_KEY_ONE)) begin
        next_unb_ok = 1'b1; // RULE1 RULE3
      end else begin
        next_unb_bad = 1'b1;
        next_sw = (pin[sel].unb_left == 8'h01) ? SW_BLOCKED : SW_BAD_KEY; // RULE8 RULE9
      end
    end else if (hdr.ins == INS_UPDATE) begin
      if (hdr.cla != CLA_UPDATE) begin
        next_sw = SW_CLA; // RULE16
      end else if (hdr.lc != dcount || (sec && hdr.lc > LC_MAX_SECURE)) begin
        next_sw = {SW1_LEN, dcount}; // RULE23
      end else if (SEL_FILE.is_df) begin
        next_sw = SW_DF; // RULE17
      end else if (SEL_FILE.is_record) begin
        next_sw = SW_RECORD; // RULE17
      end else if (SEL_FILE.invalid) begin
        next_sw = SW_INVALID; // RULE21
      end else if (!SEL_FILE.ac_ok) begin
        next_sw = SW_NO_AC; // RULE18
      end else if (end_addr > {1'b0, SEL_FILE.size}) begin
        next_sw = SW_P1P2; // RULE19 RULE22
      end else begin
        next_commit = 1'b1; // RULE16
      end
    end else begin
      next_sw = SW_INS; // RULE14
    end
  end

  // Sequencer: capture, check, commit, answer
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: if (CMD_VALID) state <= ST_CHECK;
        ST_CHECK: state <= ST_COMMIT;
        ST_COMMIT: state <= ST_DONE;
        ST_DONE: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Command capture; held stable through the check
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      hdr <= '0;
      data <= '0;
      dcount <= 8'h00;
      sec <= 1'b0;
    end else if (state == ST_IDLE && CMD_VALID) begin
      hdr <= CMD_HDR;
      data <= CMD_DATA;
      dcount <= DATA_COUNT;
      sec <= SECURE_MODE;
    end
  end

  // Pin file counters; unblock changes only in commit without memory fault, key rewrite in idle, PIN_FAIL at any time
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 2; i++) begin
        pin[i] <= '{PIN_RESET, PIN_RESET, UNBLOCK_RELOAD, UNBLOCK_RELOAD, MECH_RESET, 1'b0};
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (unb_commit && sel == i[0] && next_unb_ok) begin
          pin[i].pin_left <= i == 0 ? PIN_CFG_ONE : PIN_CFG_TWO; // RULE6
          pin[i].pin_cfg <= i == 0 ? PIN_CFG_ONE : PIN_CFG_TWO;
          pin[i].unb_left <= UNBLOCK_RELOAD; // RULE6
          pin[i].unb_max <= UNBLOCK_RELOAD; // RULE10
          pin[i].mech <= pin[i].mech - 8'h01; // RULE6
          pin[i].blocked <= 1'b0;
        end else if (unb_commit && sel == i[0] && next_unb_bad) begin
          pin[i].unb_left <= pin[i].unb_left - 8'h01; // RULE8
        end else if (APP_AUTH_KEY_WRITE && APP_AUTH_KEY_SEL == i[0] && state == ST_IDLE) begin
          pin[i].unb_left <= APP_AUTH_KEY_VALUE; // RULE11
        end
        // Wrong PIN on an unblocked file overrides an unblock's reload, on a blocked file it is dropped; placed last so a new block wins
        if (PIN_FAIL && PIN_FAIL_SEL == i[0] && !pin[i].blocked) begin
          pin[i].pin_left <= pin[i].pin_left - 8'h01;
          if (pin[i].pin_left == 8'h01) pin[i].blocked <= 1'b1; // RULE5
        end
      end
    end
  end

  // Answer, nonvolatile write strobes and status outputs, all registered
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      BUSY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_SW <= SW_RESET;
      NVM_WE <= 1'b0;
      NVM_OFFSET <= 16'h0000;
      NVM_LEN <= 8'h00;
      NEW_PIN <= 64'h0000_0000_0000_0000;
      NEW_PIN_WE <= 2'b00;
      ACCESS_GRANT <= 2'b00;
    end else begin
      BUSY <= (state != ST_IDLE) || CMD_VALID;
      RSP_VALID <= (state == ST_COMMIT);
      NVM_WE <= 1'b0;
      NEW_PIN_WE <= 2'b00;
      // Blocked files lose access; a grant from this cycle's unblock comes later and wins
      for (int i = 0; i < 2; i++) begin
        if (pin[i].blocked) ACCESS_GRANT[i] <= 1'b0; // RULE5
      end
      if (state == ST_COMMIT) begin
        // A fault seen here suppresses every write, so an error never leaves half a state
        RSP_SW <= NVM_FAULT ? SW_MEM : next_sw; // RULE12 RULE24
        if (!NVM_FAULT && next_commit) begin
          NVM_WE <= 1'b1; // RULE24
          NVM_OFFSET <= {hdr.p1, hdr.p2}; // RULE20
          NVM_LEN <= hdr.lc;
        end
        if (!NVM_FAULT && next_unb_ok) begin
          NEW_PIN <= data[63:0]; // RULE3
          NEW_PIN_WE <= sel ? 2'b10 : 2'b01;
          ACCESS_GRANT[sel] <= 1'b1; // RULE7
        end
      end
    end
  end

  // Counter mirrors
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PIN_BLOCKED <= 2'b00;
      UNB_LEFT_ONE <= 8'h00;
      UNB_LEFT_TWO <= 8'h00;
      UNB_MAX_ONE <= 8'h00;
      UNB_MAX_TWO <= 8'h00;
      MECH_ONE <= 8'h00;
      MECH_TWO <= 8'h00;
    end else begin
      PIN_BLOCKED <= {pin[1].blocked, pin[0].blocked};
      UNB_LEFT_ONE <= pin[0].unb_left;
      UNB_LEFT_TWO <= pin[1].unb_left;
      UNB_MAX_ONE <= pin[0].unb_max;
      UNB_MAX_TWO <= pin[1].unb_max;
      MECH_ONE <= pin[0].mech;
      MECH_TWO <= pin[1].mech;
    end
  end
endmodule // pubu_core

/* rtl/pubu_pkg.sv */
// Constants and types for the pin unblock and binary update command block
// What this block does
// RULE1 - Unblock recognised by INS 2C, P1 00, Lc 10h.
// RULE2 - P2 01h picks pin file one, 02h picks pin file two.
// RULE3 - Data bytes 1-8 unblock key, bytes 9-16 new PIN value.
// RULE4 - Unblock with Lc not 10h answers 6710, nothing changes.
// RULE5 - PIN counter at zero blocks PIN and denies protected files.
// RULE6 - Unblock success reloads PIN counter, unblock counter 0Ah, decrements mechanisms.
// RULE7 - Unblock success grants access and answers 9000.
// RULE8 - Wrong unblock key with attempts left decrements counter, answers 6300.
// RULE9 - Unblock counter at zero: always answer 6983, never unblock.
// RULE10 - Unblock writes 0Ah into byte 22, maximum unblock attempts.
// RULE11 - Byte 23 remaining attempts rewritable after app auth key check.
// RULE12 - Nonvolatile memory fault during execution answers 6581.
// RULE13 - Bad P1 or P2 on unblock answers 6B00.
// RULE14 - 6D00 unknown INS, 6E00 bad class, 6F00 internal fault.
// RULE15 - USB mode length mismatch with P3 answers 6C then P3.
// RULE16 - Binary update class C0, INS D6, offset P1 high, P2 low.
// RULE17 - Binary update only on selected transparent file, not record files.
// RULE18 - Binary update needs its access condition satisfied first.
// RULE19 - Binary update never writes past the allocated file size.
// RULE20 - Offset zero-based big-endian from address 0000.
// RULE21 - Binary update refused on an invalidated file.
// RULE22 - Offset outside file answers 6B00; success answers 9000.
// RULE23 - Update at most 255 bytes, 251 in secure messaging; else 67xx.
// RULE24 - Error status means no partial nonvolatile write.
package pubu_pkg;
  localparam logic [7:0] INS_UNBLOCK = 8'h2C;
  localparam logic [7:0] INS_UPDATE = 8'hD6;
  localparam logic [7:0] CLA_UNBLOCK = 8'hF0;
  localparam logic [7:0] CLA_UPDATE = 8'hC0;
  localparam logic [7:0] LC_UNBLOCK = 8'h10;
  localparam logic [7:0] P1_UNBLOCK = 8'h00;
  localparam logic [7:0] P2_PIN_ONE = 8'h01;
  localparam logic [7:0] P2_PIN_TWO = 8'h02;
  localparam logic [7:0] LC_MAX_PLAIN = 8'hFF;
  localparam logic [7:0] LC_MAX_SECURE = 8'hFB;
  localparam logic [7:0] UNBLOCK_RELOAD = 8'h0A;
  localparam logic [7:0] MAX_UNBLOCK_BYTE = 8'h16;
  localparam logic [7:0] REM_UNBLOCK_BYTE = 8'h17;
  localparam logic [7:0] MECH_RESET = 8'h0A;
  localparam logic [7:0] PIN_RESET = 8'h03;
  localparam int KEY_BYTES = 8;
  localparam int DATA_BYTES = 16;
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_BAD_KEY = 16'h6300;
  localparam logic [15:0] SW_MEM = 16'h6581;
  localparam logic [15:0] SW_LC = 16'h6710;
  localparam logic [7:0] SW1_LEN = 8'h67;
  localparam logic [7:0] SW1_USB = 8'h6C;
  localparam logic [15:0] SW_INVALID = 16'h6283;
  localparam logic [15:0] SW_NO_AC = 16'h6982;
  localparam logic [15:0] SW_BLOCKED = 16'h6983;
  localparam logic [15:0] SW_DF = 16'h6986;
  localparam logic [15:0] SW_RECORD = 16'h6A80;
  localparam logic [15:0] SW_P1P2 = 16'h6B00;
  localparam logic [15:0] SW_INS = 16'h6D00;
  localparam logic [15:0] SW_CLA = 16'h6E00;
  localparam logic [15:0] SW_TECH = 16'h6F00;
  localparam logic [15:0] SW_RESET = 16'h0000;

  // Command header as taken from the host
  typedef struct packed {
    logic [7:0] cla;
    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] lc;
  } pubu_hdr_t;

  // Selected file descriptor from the file system
  typedef struct packed {
    logic is_df;
    logic is_record;
    logic invalid;
    logic ac_ok;
    logic [15:0] size;
  } pubu_file_t;

  // One pin file's counters
  typedef struct packed {
    logic [7:0] pin_left;
    logic [7:0] pin_cfg;
    logic [7:0] unb_max;
    logic [7:0] unb_left;
    logic [7:0] mech;
    logic blocked;
  } pubu_pin_t;

  typedef enum {ST_IDLE, ST_CHECK, ST_COMMIT, ST_DONE} pubu_state_t;
endpackage

/* verification/pin_unblock_and_binary_update_tb_top.sv */
// Testbench for the pin unblock and binary update block
`timescale 1ns/1ps
module pin_unblock_and_binary_update_tb_top;
  import pubu_pkg::*;
  logic MCLK, RST, CMD_VALID, USB_MODE, USB_LEN_MISMATCH, SECURE_MODE, PIN_FAIL, PIN_FAIL_SEL;
  logic APP_AUTH_KEY_WRITE, APP_AUTH_KEY_SEL, NVM_FAULT, TECH_FAULT, BUSY, RSP_VALID, NVM_WE;
  pubu_hdr_t CMD_HDR;
  pubu_file_t SEL_FILE;
  logic [127:0] CMD_DATA;
  logic [63:0] UNBLOCK_KEY_ONE, UNBLOCK_KEY_TWO, NEW_PIN, got_pin;
  logic [7:0] USB_P3, DATA_COUNT, PIN_CFG_ONE, PIN_CFG_TWO, APP_AUTH_KEY_VALUE, NVM_LEN;
  logic [7:0] UNB_LEFT_ONE, UNB_LEFT_TWO, UNB_MAX_ONE, UNB_MAX_TWO, MECH_ONE, MECH_TWO;
  logic [15:0] RSP_SW, NVM_OFFSET;
  logic [1:0] NEW_PIN_WE, PIN_BLOCKED, ACCESS_GRANT;
  logic [2:0] got_we;
  logic [23:0] got_off;
  int fails, num_checks;
  localparam logic [63:0] K1 = 64'h1111_2222_3333_4444;
  localparam logic [63:0] K2 = 64'h5555_6666_7777_8888;
  localparam logic [63:0] NP = 64'h0123_4567_89AB_CDEF;
  localparam logic [23:0] UNB = {CLA_UNBLOCK, INS_UNBLOCK, P1_UNBLOCK};
  localparam logic [15:0] UPD = {CLA_UPDATE, INS_UPDATE};
  pubu_core i_dut (.*);
  pubu_host i_host (.*);
  // 250 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  task automatic close_out();
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge MCLK);
  endtask
  // Wrong PIN entries on the file picked by PIN_FAIL_SEL, one per two cycles
  task automatic fail_pin(input int n);
    repeat (n) begin
      PIN_FAIL = 1'b1;
      step(1);
      PIN_FAIL = 1'b0;
      step(1);
    end
  endtask
  // One command; strobes captured in the single answer cycle
  task automatic run(input pubu_hdr_t h, input logic [127:0] d, input logic [15:0] exp);
    int n;
    logic ok;
    i_host.send(h, d, ok);
    if (!ok) begin
      fails++;
      close_out();
    end
    n = 0;
    while (RSP_VALID !== 1'b1 && n < 8) begin
      @(negedge MCLK);
      n++;
    end
    if (n == 8) begin
      fails++;
      close_out();
    end
    got_we = {NVM_WE, NEW_PIN_WE};
    got_off = {NVM_OFFSET, NVM_LEN};
    got_pin = NEW_PIN;
    cmp(64'(RSP_SW), 64'(exp));
    if (exp !== SW_OK) cmp(64'(got_we), 64'h0);
  endtask
  // Main sequence, inputs change on the falling edge
  initial begin
    {RST, USB_MODE, USB_LEN_MISMATCH, SECURE_MODE, PIN_FAIL, PIN_FAIL_SEL} = 6'h01 << 5;
    {APP_AUTH_KEY_WRITE, APP_AUTH_KEY_SEL, APP_AUTH_KEY_VALUE} = '0;
    {NVM_FAULT, TECH_FAULT, USB_P3} = '0;
    {UNBLOCK_KEY_ONE, UNBLOCK_KEY_TWO, PIN_CFG_ONE, PIN_CFG_TWO} = {K1, K2, 16'h0504};
    SEL_FILE = {4'h1, 16'h0100};
    // Unblock commands carry their full 16 data bytes
    DATA_COUNT = LC_UNBLOCK;
    fails = 0;
    num_checks = 0;
    step(2);
    RST = 1'b0;
    step(1);
    fail_pin(3);
    step(2);
    cmp(64'({PIN_BLOCKED, ACCESS_GRANT}), 64'h4);
    run({UNB, P2_PIN_ONE, LC_UNBLOCK}, {K1, NP}, SW_OK);
    cmp({got_we, got_pin[60:0]}, {3'h1, NP[60:0]});
    step(2);
    cmp({PIN_BLOCKED[0], ACCESS_GRANT[0], UNB_MAX_ONE, UNB_LEFT_ONE, MECH_ONE}, 64'h1_0A0A_09);
    // Attempts reloaded to five: four wrong entries leave it open, the fifth blocks again
    fail_pin(4);
    cmp(64'(PIN_BLOCKED[0]), 64'h0);
    fail_pin(1);
    step(1);
    cmp(64'({PIN_BLOCKED[0], ACCESS_GRANT[0]}), 64'h2);
    run({UNB, P2_PIN_ONE, 8'h0F}, {K1, NP}, SW_LC);
    run({UNB, P2_PIN_ONE, 8'h11}, {K1, NP}, SW_LC);
    run({CLA_UNBLOCK, INS_UNBLOCK, 8'h01, P2_PIN_ONE, LC_UNBLOCK}, {K1, NP}, SW_P1P2);
    run({UNB, 8'h03, LC_UNBLOCK}, {K1, NP}, SW_P1P2);
    run({8'h00, INS_UNBLOCK, P1_UNBLOCK, P2_PIN_ONE, LC_UNBLOCK}, {K1, NP}, SW_CLA);
    run({CLA_UPDATE, 8'hA4, 24'h08}, 128'h0, SW_INS);
    TECH_FAULT = 1'b1;
    run({UNB, P2_PIN_ONE, LC_UNBLOCK}, {K1, NP}, SW_TECH);
    {TECH_FAULT, USB_MODE, USB_LEN_MISMATCH, USB_P3} = 11'h0_310;
    run({UNB, P2_PIN_ONE, LC_UNBLOCK}, {K1, NP}, {SW1_USB, 8'h10});
    {USB_MODE, USB_LEN_MISMATCH} = 2'h0;
    for (int i = 0; i < 10; i++) begin
      run({UNB, P2_PIN_TWO, LC_UNBLOCK}, {K1, NP}, (i == 9) ? SW_BLOCKED : SW_BAD_KEY);
    end
    run({UNB, P2_PIN_TWO, LC_UNBLOCK}, {K2, NP}, SW_BLOCKED);
    // Key rewrite is ignored until the previous command has fully retired
    step(1);
    {APP_AUTH_KEY_SEL, APP_AUTH_KEY_VALUE, APP_AUTH_KEY_WRITE} = 10'h205;
    step(1);
    APP_AUTH_KEY_WRITE = 1'b0;
    step(2);
    cmp(64'(UNB_LEFT_TWO), 64'h2);
    run({UNB, P2_PIN_TWO, LC_UNBLOCK}, {K2, NP}, SW_OK);
    cmp(64'(got_we), 64'h2);
    step(2);
    cmp({ACCESS_GRANT[1], UNB_MAX_TWO, UNB_LEFT_TWO, MECH_TWO}, 64'h1_0A0A_09);
    DATA_COUNT = 8'h08;
    run({UPD, 16'h00F0, 8'h08}, 128'h0, SW_OK);
    cmp({got_we, got_off}, {3'h4, 24'h00F0_08});
    run({UPD, 16'h0100, 8'h08}, 128'h0, SW_P1P2);
    run({UPD, 16'h0000, 8'h09}, 128'h0, {SW1_LEN, 8'h08});
    {SECURE_MODE, DATA_COUNT} = 9'h1FC;
    run({UPD, 16'h0000, 8'hFC}, 128'h0, {SW1_LEN, 8'hFC});
    {SECURE_MODE, DATA_COUNT, NVM_FAULT} = 10'h011;
    run({UPD, 16'h0000, 8'h08}, 128'h0, SW_MEM);
    NVM_FAULT = 1'b0;
    SEL_FILE.ac_ok = 1'b0;
    run({UPD, 16'h0000, 8'h08}, 128'h0, SW_NO_AC);
    SEL_FILE = {4'h3, 16'h0100};
    run({UPD, 16'h0000, 8'h08}, 128'h0, SW_INVALID);
    SEL_FILE = {4'h5, 16'h0100};
    run({UPD, 16'h0000, 8'h08}, 128'h0, SW_RECORD);
    SEL_FILE = {4'h9, 16'h0100};
    run({UPD, 16'h0000, 8'h08}, 128'h0, SW_DF);
    close_out();
  end
endmodule // pin_unblock_and_binary_update_tb_top
bind pubu_core pubu_props i_props (.*);

/* verification/pubu_host.sv */
// Host terminal model offering command headers and data
`timescale 1ns/1ps
module pubu_host (
  input wire logic MCLK,
  input wire logic BUSY,
  input wire logic RSP_VALID,
  output logic CMD_VALID,
  output pubu_pkg::pubu_hdr_t CMD_HDR,
  output logic [127:0] CMD_DATA
);
  import pubu_pkg::*;
  // Idle lines carry junk, never a stale command
  initial begin
    CMD_VALID = 1'b0;
    CMD_HDR = '1;
    CMD_DATA = '1;
  end
  // Offer when idle, hold to the taking edge, then scramble the lines
  task automatic send(input pubu_hdr_t h, input logic [127:0] d, output logic ok);
    int n;
    n = 0;
    while ((BUSY !== 1'b0 || RSP_VALID !== 1'b0) && n < 20) begin
      @(negedge MCLK);
      n++;
    end
    // A block that never went idle is reported to the caller as a hang
    ok = (n < 20);
    CMD_HDR = h;
    CMD_DATA = d;
    CMD_VALID = 1'b1;
    @(posedge MCLK);
    @(negedge MCLK);
    CMD_VALID = 1'b0;
    CMD_HDR = ~h;
    CMD_DATA = ~d;
  endtask
endmodule // pubu_host

/* verification/pubu_props.sv */
// Port-level checker for the pin unblock and binary update block
`timescale 1ns/1ps
module pubu_props (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CMD_VALID,
  input wire pubu_pkg::pubu_hdr_t CMD_HDR,
  input wire logic TECH_FAULT,
  input wire logic USB_MODE,
  input wire logic NVM_FAULT,
  input wire logic BUSY,
  input wire logic RSP_VALID,
  input wire logic [15:0] RSP_SW,
  input wire logic NVM_WE,
  input wire logic [1:0] NEW_PIN_WE,
  input wire logic [1:0] PIN_BLOCKED,
  input wire logic [1:0] ACCESS_GRANT,
  input wire logic [7:0] UNB_LEFT_ONE,
  input wire logic [7:0] UNB_MAX_ONE
);
  import pubu_pkg::*;
  logic take;
  logic plain;
  logic unb_cmd;
  // Taking edge; faults kept out so command checks are the ones that answer
  assign take = CMD_VALID && !BUSY && !RSP_VALID;
  assign plain = !TECH_FAULT && !USB_MODE && !NVM_FAULT;
  assign unb_cmd = CMD_HDR.cla == CLA_UNBLOCK && CMD_HDR.ins == INS_UNBLOCK;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_taken;
    take && plain;
  endsequence
  chk_answer_delay: assert property (take |-> ##3 RSP_VALID)
    else $error("answer not three cycles after take");
  chk_lc_refuse: assert property (
    s_taken ##0 unb_cmd && CMD_HDR.p1 == P1_UNBLOCK && CMD_HDR.p2 == P2_PIN_ONE
      && CMD_HDR.lc != LC_UNBLOCK |-> ##3 RSP_SW == SW_LC) else $error("bad length accepted");
  chk_p2_refuse: assert property (
    s_taken ##0 unb_cmd && CMD_HDR.p2 > P2_PIN_TWO |-> ##3 RSP_SW == SW_P1P2)
    else $error("bad file select accepted");
  chk_ins_refuse: assert property (
    s_taken ##0 CMD_HDR.ins != INS_UNBLOCK && CMD_HDR.ins != INS_UPDATE
      |-> ##3 RSP_SW == SW_INS) else $error("unknown opcode accepted");
  chk_tech_fault: assert property (take && TECH_FAULT |-> ##3 RSP_SW == SW_TECH)
    else $error("internal fault not reported");
  chk_write_ok: assert property (
    NVM_WE || |NEW_PIN_WE |-> RSP_VALID && RSP_SW == SW_OK) else $error("write without success");
  chk_unblock_reload: assert property (
    NEW_PIN_WE[0] |-> ##[1:2] UNB_MAX_ONE == UNBLOCK_RELOAD && UNB_LEFT_ONE == UNBLOCK_RELOAD)
    else $error("unblock counters not reloaded");
  chk_grant_ok: assert property ($rose(ACCESS_GRANT[0]) |-> RSP_VALID && RSP_SW == SW_OK)
    else $error("grant without success");
  chk_block_deny: assert property ($rose(PIN_BLOCKED[0]) |-> !ACCESS_GRANT[0])
    else $error("blocked file still granted");
endmodule // pubu_props
